// ===== hlt_far_model.sv
/*
 * Far-side model of the timer: free-running oscillator levels and the
 * external reset candidates, whose levels the bench sets.
 * Assumes core_clk is the only timebase; oscillators run in sleep too.
 */
`timescale 1ns/1ps
module hlt_far_model (
	input  wire logic              core_clk,
	input  wire logic [4:0]        ersLevel,
	output hlt_pkg::hlt_osc_t      oscIn,
	output hlt_pkg::hlt_ers_t      ersIn
);
	import hlt_pkg::*;
	int         cnt_r = 0;
	logic [3:0] osc_r = 4'h0;

	// Bit i toggles every i+2 cycles, so each source has its own period
	always_ff @(posedge core_clk) begin
		cnt_r <= cnt_r + 1;
		for (int i = 0; i < 4; i++) begin
			if (cnt_r % (i + 2) == 0) begin
				osc_r[i] <= ~osc_r[i];
			end
		end
	end

	assign oscIn = hlt_osc_t'(osc_r);
	// Pin level doubles as the pin clock; it moves only when the bench says
	assign ersIn = hlt_ers_t'(ersLevel);
endmodule

// ===== hlt_pkg.sv
/*
 * Shared constants and types of the period-limit timer: register
 * indices, field positions, reset values, mode and source codes.
 * Assumes a 100 MHz core clock that also serves as the system clock.
 */
package hlt_pkg;

	// Register indices; byte address is four times the index
	localparam logic [11:0] HLT_IDX_COUNT   = 12'h28C;
	localparam logic [11:0] HLT_IDX_PERIOD  = 12'h28D;
	localparam logic [11:0] HLT_IDX_TCON    = 12'h28E;
	localparam logic [11:0] HLT_IDX_LIMIT   = 12'h28F;
	localparam logic [11:0] HLT_IDX_CLKSRC  = 12'h290;
	localparam logic [11:0] HLT_IDX_ERSSEL  = 12'h291;
	localparam logic [11:0] HLT_IDX_STATUS  = 12'h292;
	localparam logic [11:0] HLT_IDX_MASK    = 12'h293;
	localparam int          HLT_ADDR_W      = 14;

	// Reset values
	localparam logic [7:0]  HLT_RST_COUNT   = 8'h00;
	localparam logic [7:0]  HLT_RST_PERIOD  = 8'hFF;
	localparam logic [7:0]  HLT_RST_TCON    = 8'h00;
	localparam logic [7:0]  HLT_RST_LIMIT   = 8'h00;
	localparam logic [2:0]  HLT_RST_CLKSRC  = 3'h0;
	localparam logic [3:0]  HLT_RST_ERSSEL  = 4'h0;

	// Status and mask bit positions
	localparam int          HLT_ST_POST     = 0;
	localparam int          HLT_ST_MATCH    = 1;
	localparam int          HLT_ST_W        = 2;

	// Instruction clock is core clock divided by four
	localparam logic [1:0]  HLT_INSTR_LAST  = 2'h3;

	// Clock source codes
	localparam logic [2:0]  HLT_CS_PIN      = 3'h0;
	localparam logic [2:0]  HLT_CS_INSTR    = 3'h1;
	localparam logic [2:0]  HLT_CS_SYS      = 3'h2;
	localparam logic [2:0]  HLT_CS_HFOSC    = 3'h3;
	localparam logic [2:0]  HLT_CS_LFOSC    = 3'h4;
	localparam logic [2:0]  HLT_CS_MF500    = 3'h5;
	localparam logic [2:0]  HLT_CS_MF32     = 3'h6;

	// External reset source codes
	localparam logic [3:0]  HLT_RS_PIN      = 4'h0;
	localparam logic [3:0]  HLT_RS_CCP1     = 4'h1;
	localparam logic [3:0]  HLT_RS_CCP2     = 4'h2;
	localparam logic [3:0]  HLT_RS_PWM3     = 4'h3;
	localparam logic [3:0]  HLT_RS_PWM4     = 4'h4;

	// Control modes; all but HLT_M_FREE implemented beyond plain software gating
	localparam logic [4:0]  HLT_M_FREE      = 5'h00;
	localparam logic [4:0]  HLT_M_ONESHOT   = 5'h08;
	localparam logic [4:0]  HLT_M_OS_RISE   = 5'h09;
	localparam logic [4:0]  HLT_M_OS_FALL   = 5'h0A;
	localparam logic [4:0]  HLT_M_OS_BOTH   = 5'h0B;
	localparam logic [4:0]  HLT_M_MS_RISE   = 5'h11;
	localparam logic [4:0]  HLT_M_MS_FALL   = 5'h12;
	localparam logic [4:0]  HLT_M_MS_BOTH   = 5'h13;
	localparam logic [4:0]  HLT_M_LV_LOW    = 5'h16;
	localparam logic [4:0]  HLT_M_LV_HIGH   = 5'h17;

	typedef struct packed {
		logic       on;
		logic [2:0] prescaleSelect;
		logic [3:0] postscaleSelect;
	} hlt_tcon_t;

	typedef struct packed {
		logic       prescalerSync;
		logic       clockEdgePolarity;
		logic       onBitSync;
		logic [4:0] mode;
	} hlt_limit_t;

	// Oscillator inputs, sampled as levels
	typedef struct packed {
		logic mf32;
		logic mf500;
		logic lf;
		logic hf;
	} hlt_osc_t;

	// External reset candidates
	typedef struct packed {
		logic pulseUnit4Output;
		logic pulseUnit3Output;
		logic capcompUnit2Output;
		logic capcompUnit1Output;
		logic inputPinRoute;
	} hlt_ers_t;

	typedef enum logic [1:0] {
		HLT_BUS_IDLE = 2'b00,
		HLT_BUS_ACK  = 2'b01
	} hlt_bus_t;

endpackage

// ===== hlt_timer.sv
/*
 * 8-bit timer with period limit, prescaler, postscaler, selectable
 * clock and external reset sources, an Avalon-MM register slave and
 * a masked level interrupt.
 * Assumes every input is synchronous to core_clk; oscillator and pin
 * clock sources arrive as levels far slower than core_clk.
 */
// The Avalon-MM register port was left to the implementer.
//
// Overview of operation
// - Prescaler sync set: no counting during sleep
// - Prescaler sync clear: counts in sleep if clocked
// - Internal oscillator source stays running in sleep
// - Counter equal to period clears on next tick
// - Counter readable, writable, resets to zero
// - On bit low resets prescaler, postscaler and state machines
// - Hardware clears on bit in one-shot modes
// - Prescaler divides by two to field power
// - Postscaler ratio is field plus one
// - Prescaler sync aligns ticks to instruction clock
// - Polarity bit picks falling or rising edge
// - On sync delays counting two input clocks
// - Mode field picks control; stop keeps count
// - Clock source field selects one of seven
// - Reset source field selects one of five
// - Software one-shot clears on bit at match
`timescale 1ns/1ps
module hlt_timer (
	input  wire logic                  core_clk,
	input  wire logic                  rstn,
	input  wire logic [hlt_pkg::HLT_ADDR_W-1:0] address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [31:0]           writedata,
	input  wire logic [3:0]            byteenable,
	output logic      [31:0]           readdata,
	output logic                       waitrequest,
	input  wire logic                  sleepActive,
	input  wire hlt_pkg::hlt_osc_t     oscIn,
	input  wire hlt_pkg::hlt_ers_t     ersIn,
	output logic                       oscKeepAlive,
	output logic                       timerEvent,
	output logic                       irq
);
	import hlt_pkg::*;

	hlt_bus_t   busState_r;
	logic [7:0] count_r, period_r;
	hlt_tcon_t  tcon_r;
	hlt_limit_t limit_r;
	logic [2:0] clkSrc_r;
	logic [3:0] ersSel_r;
	logic [HLT_ST_W-1:0] status_r, mask_r;
	logic [31:0] rdData_r;
	logic [1:0] instrDiv_r;
	logic [1:0] onSync_r;
	logic [6:0] presc_r;
	logic [3:0] post_r;
	logic       srcPrev_r, ersPrev_r, pend_r, started_r, evPulse_r;

	logic        busReq, busDone, addrOk, wrEn;
	logic [11:0] regIdx;
	logic [7:0]  wrByte;
	logic        instrEn, srcLvl, srcRuns, clkEdge, runOn;
	logic [6:0]  prescLimit;
	logic        prescOut, timerTick, ers, ersEdge, match, postDone;
	logic        edgeMode, levelMode, levelHold, modeRun, osMode, countEn;
	logic [HLT_ST_W-1:0] stSet;

	// Avalon slave: one wait state, answer on the second edge
	assign busReq  = read || write;
	assign busDone = busReq && (busState_r == HLT_BUS_ACK);
	assign waitrequest = busReq && (busState_r != HLT_BUS_ACK);
	assign regIdx  = address[HLT_ADDR_W-1:2];
	assign addrOk  = (address[1:0] == 2'h0);
	assign wrEn    = write && busDone && addrOk && byteenable[0];
	assign wrByte  = writedata[7:0];
	assign readdata = rdData_r;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			busState_r <= HLT_BUS_IDLE;
		end else begin
			case (busState_r)
				HLT_BUS_IDLE: busState_r <= busReq ? HLT_BUS_ACK
				                                   : HLT_BUS_IDLE;
				HLT_BUS_ACK:  busState_r <= HLT_BUS_IDLE;
				default:      busState_r <= HLT_BUS_IDLE;
			endcase
		end
	end

	// Read data captured in the wait cycle; unmapped reads give zero
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rdData_r <= 32'h0000_0000;
		end else if (read && !busDone) begin
			rdData_r <= 32'h0000_0000;
			if (addrOk) begin
				case (regIdx)
					HLT_IDX_COUNT:  rdData_r[7:0] <= count_r;
					HLT_IDX_PERIOD: rdData_r[7:0] <= period_r;
					HLT_IDX_TCON:   rdData_r[7:0] <= tcon_r;
					HLT_IDX_LIMIT:  rdData_r[7:0] <= limit_r;
					HLT_IDX_CLKSRC: rdData_r[2:0] <= clkSrc_r;
					HLT_IDX_ERSSEL: rdData_r[3:0] <= ersSel_r;
					HLT_IDX_STATUS: rdData_r[HLT_ST_W-1:0] <= status_r;
					HLT_IDX_MASK:   rdData_r[HLT_ST_W-1:0] <= mask_r;
					default:        rdData_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Configuration registers
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			period_r <= HLT_RST_PERIOD;
			limit_r  <= HLT_RST_LIMIT;
			clkSrc_r <= HLT_RST_CLKSRC;
			ersSel_r <= HLT_RST_ERSSEL;
			mask_r   <= '0;
		end else if (wrEn) begin
			case (regIdx)
				HLT_IDX_PERIOD: period_r <= wrByte;
				HLT_IDX_LIMIT:  limit_r  <= wrByte;
				HLT_IDX_CLKSRC: clkSrc_r <= wrByte[2:0];
				HLT_IDX_ERSSEL: ersSel_r <= wrByte[3:0];
				HLT_IDX_MASK:   mask_r   <= wrByte[HLT_ST_W-1:0];
				default:        mask_r   <= mask_r;
			endcase
		end
	end

	// Instruction clock enable from a divide-by-four
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			instrDiv_r <= 2'h0;
		end else begin
			instrDiv_r <= instrDiv_r + 2'h1;
		end
	end
	assign instrEn = (instrDiv_r == HLT_INSTR_LAST);

	// Clock source select; reserved code gives no clock
	always_comb begin
		case (clkSrc_r)
			HLT_CS_PIN:   srcLvl = ersIn.inputPinRoute;
			HLT_CS_HFOSC: srcLvl = oscIn.hf;
			HLT_CS_LFOSC: srcLvl = oscIn.lf;
			HLT_CS_MF500: srcLvl = oscIn.mf500;
			HLT_CS_MF32:  srcLvl = oscIn.mf32;
			default:      srcLvl = 1'b0;
		endcase
	end

	// Core-derived clocks stop in sleep; oscillators and pin do not
	assign srcRuns = !(sleepActive &&
	                   (clkSrc_r == HLT_CS_INSTR || clkSrc_r == HLT_CS_SYS));
	assign oscKeepAlive = sleepActive && tcon_r.on &&
	                      clkSrc_r >= HLT_CS_HFOSC && clkSrc_r <= HLT_CS_MF32;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			srcPrev_r <= 1'b0;
		end else begin
			srcPrev_r <= srcLvl;
		end
	end

	always_comb begin
		case (clkSrc_r)
			HLT_CS_INSTR: clkEdge = instrEn;
			HLT_CS_SYS:   clkEdge = 1'b1;
			default:      clkEdge = limit_r.clockEdgePolarity
			                        ? (srcPrev_r && !srcLvl)
			                        : (!srcPrev_r && srcLvl);
		endcase
		// Sleep gates the source; sync mode cannot run in sleep
		if (!srcRuns || (sleepActive && limit_r.prescalerSync)) begin
			clkEdge = 1'b0;
		end
	end

	// On bit resynchronised through two input clock edges
	always_ff @(posedge core_clk) begin
		if (!rstn || !tcon_r.on) begin
			onSync_r <= 2'b00;
		end else if (clkEdge) begin
			onSync_r <= {onSync_r[0], tcon_r.on};
		end
	end
	assign runOn = tcon_r.on &&
	               (!limit_r.onBitSync || onSync_r[1]);

	// Prescaler counts input edges, reset while off
	always_comb begin
		prescLimit = 7'h00;
		for (int i = 0; i < 7; i++) begin
			if (i < int'(tcon_r.prescaleSelect)) begin
				prescLimit[i] = 1'b1;
			end
		end
	end
	assign prescOut = clkEdge && runOn && (presc_r == prescLimit);

	always_ff @(posedge core_clk) begin
		if (!rstn || !runOn) begin
			presc_r <= 7'h00;
		end else if (clkEdge) begin
			presc_r <= prescOut ? 7'h00 : presc_r + 7'h01;
		end
	end

	// Synchronised prescaler output waits for instruction clock
	always_ff @(posedge core_clk) begin
		if (!rstn || !runOn) begin
			pend_r <= 1'b0;
		end else begin
			pend_r <= limit_r.prescalerSync && (pend_r || prescOut) &&
			          !(instrEn && !sleepActive);
		end
	end
	// Pending tick waits out sleep; nothing ticks once the timer is off
	assign timerTick = runOn && (limit_r.prescalerSync
	                   ? ((pend_r || prescOut) && instrEn && !sleepActive)
	                   : prescOut);

	// External reset source select; reserved codes read low
	always_comb begin
		case (ersSel_r)
			HLT_RS_PIN:  ers = ersIn.inputPinRoute;
			HLT_RS_CCP1: ers = ersIn.capcompUnit1Output;
			HLT_RS_CCP2: ers = ersIn.capcompUnit2Output;
			HLT_RS_PWM3: ers = ersIn.pulseUnit3Output;
			HLT_RS_PWM4: ers = ersIn.pulseUnit4Output;
			default:     ers = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ersPrev_r <= 1'b0;
		end else begin
			ersPrev_r <= ers;
		end
	end

	// Mode decode; codes not listed here run as software gated
	always_comb begin
		edgeMode  = 1'b0;
		levelMode = 1'b0;
		osMode    = 1'b0;
		case (limit_r.mode)
			HLT_M_ONESHOT: osMode = 1'b1;
			HLT_M_OS_RISE, HLT_M_OS_FALL, HLT_M_OS_BOTH: begin
				edgeMode = 1'b1;
				osMode   = 1'b1;
			end
			HLT_M_MS_RISE, HLT_M_MS_FALL, HLT_M_MS_BOTH: edgeMode = 1'b1;
			HLT_M_LV_LOW, HLT_M_LV_HIGH: begin
				levelMode = 1'b1;
				osMode    = 1'b1;
			end
			default: osMode = 1'b0;
		endcase
		case (limit_r.mode[1:0])
			2'b01:   ersEdge = !ersPrev_r && ers;
			2'b10:   ersEdge = ersPrev_r && !ers;
			2'b11:   ersEdge = ersPrev_r != ers;
			default: ersEdge = 1'b0;
		endcase
	end

	// Level modes: bit 0 of the mode is the reset level
	assign levelHold = levelMode && (ers == limit_r.mode[0]);
	assign match     = (count_r == period_r);
	assign modeRun   = edgeMode ? started_r : !levelHold;
	assign countEn   = timerTick && modeRun;
	assign postDone  = countEn && match &&
	                   (post_r == tcon_r.postscaleSelect);

	// Edge modes wait for a trigger after on, rearm at match
	always_ff @(posedge core_clk) begin
		if (!rstn || !runOn) begin
			started_r <= 1'b0;
		end else if (countEn && match) begin
			started_r <= 1'b0;
		end else if (edgeMode && ersEdge) begin
			started_r <= 1'b1;
		end
	end

	// Counter: software write first, stop keeps the value
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			count_r <= HLT_RST_COUNT;
		end else if (wrEn && regIdx == HLT_IDX_COUNT) begin
			count_r <= wrByte;
		end else if (runOn && levelHold) begin
			count_r <= 8'h00;
		end else if (countEn) begin
			count_r <= match ? 8'h00 : count_r + 8'h01;
		end
	end

	// Postscaler counts period matches
	always_ff @(posedge core_clk) begin
		if (!rstn || !runOn) begin
			post_r <= 4'h0;
		end else if (countEn && match) begin
			post_r <= postDone ? 4'h0 : post_r + 4'h1;
		end
	end

	// Control register; a software write beats the hardware clear
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tcon_r <= HLT_RST_TCON;
		end else if (wrEn && regIdx == HLT_IDX_TCON) begin
			tcon_r <= wrByte;
		end else if (countEn && match && osMode) begin
			tcon_r.on <= 1'b0;
		end
	end

	// Sticky status, write one to clear, new events win
	assign stSet = {countEn && match, postDone};
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			status_r <= '0;
		end else if (wrEn && regIdx == HLT_IDX_STATUS) begin
			status_r <= (status_r & ~wrByte[HLT_ST_W-1:0]) | stSet;
		end else begin
			status_r <= status_r | stSet;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			evPulse_r <= 1'b0;
		end else begin
			evPulse_r <= postDone;
		end
	end
	assign timerEvent = evPulse_r;
	assign irq = |(status_r & mask_r);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	matchClear_a: assert property (countEn && match &&
		!(wrEn && regIdx == HLT_IDX_COUNT) |=> count_r == 8'h00)
		else $error("counter did not clear after period match");
	sleepHold_a: assert property (sleepActive &&
		limit_r.prescalerSync |-> !timerTick)
		else $error("timer ticked in sleep with prescaler sync");
	offReset_a: assert property (!tcon_r.on |=> presc_r == 7'h00 &&
		post_r == 4'h0 && !started_r && onSync_r == 2'b00)
		else $error("state not reset while timer off");
	stopKeep_a: assert property (!runOn && !levelHold &&
		!(wrEn && regIdx == HLT_IDX_COUNT) |=> $stable(count_r))
		else $error("counter moved while stopped");
	oneShotOff_a: assert property (osMode && countEn && match &&
		!(wrEn && regIdx == HLT_IDX_TCON) |=> !tcon_r.on ##1 !runOn)
		else $error("one-shot did not clear the on bit");
	postFlag_a: assert property (postDone |=> status_r[HLT_ST_POST]
		&& timerEvent ##1 !timerEvent || $past(postDone))
		else $error("postscaler event not flagged");
	prescRatio_a: assert property (prescOut |->
		presc_r == 7'((8'h01 << tcon_r.prescaleSelect) - 8'h01))
		else $error("prescaler output at wrong count");
	syncAlign_a: assert property (limit_r.prescalerSync &&
		timerTick |-> instrEn)
		else $error("synchronised tick off the instruction clock");
	onSyncDelay_a: assert property (limit_r.onBitSync &&
		!onSync_r[1] |-> !timerTick)
		else $error("counting began before two input clocks");
	oscAlive_a: assert property (sleepActive && tcon_r.on &&
		clkSrc_r == HLT_CS_LFOSC |-> oscKeepAlive)
		else $error("oscillator not held during sleep");
	busWait_a: assert property (busReq && busState_r == HLT_BUS_IDLE
		|-> waitrequest ##1 (!busReq || !waitrequest))
		else $error("bus answer not on second edge");

	oneShotDone_c: cover property (osMode && countEn && match);
	postEvent_c: cover property (postDone && tcon_r.postscaleSelect != 4'h0);
	edgeStart_c: cover property (edgeMode && $rose(started_r));
	sleepCount_c: cover property (sleepActive && countEn);

	initial begin
		if (HLT_ADDR_W < 14) begin
			$error("address too narrow for register map");
		end
	end

endmodule

// ===== tb.sv
/*
 * Self-checking bench of the period-limit timer: register access,
 * scaling, sources, one-shot, sleep, polarity, sync and reset select.
 * Assumes hlt_pkg, hlt_timer and hlt_far_model compiled before it.
 */
`timescale 1ns/1ps
module tb;
	import hlt_pkg::*;
	logic                  core_clk = 1'b0;
	logic                  rstn = 1'b0;
	logic [HLT_ADDR_W-1:0] address = '0;
	logic                  read = 1'b0;
	logic                  write = 1'b0;
	logic [31:0]           writedata = 32'h0;
	logic [31:0]           readdata;
	logic                  waitrequest;
	logic                  sleepActive = 1'b0;
	logic [4:0]            ersLevel = 5'h00;
	hlt_osc_t              oscIn;
	hlt_ers_t              ersIn;
	logic                  oscKeepAlive;
	logic                  timerEvent;
	logic                  irq;
	logic [7:0]            rv;
	int                    n_mismatch = 0;
	int                    samples_checked = 0;

	hlt_timer DUT (.core_clk(core_clk), .rstn(rstn), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
		.sleepActive(sleepActive), .oscIn(oscIn), .ersIn(ersIn),
		.oscKeepAlive(oscKeepAlive), .timerEvent(timerEvent), .irq(irq));

	hlt_far_model far (.core_clk(core_clk), .ersLevel(ersLevel),
		.oscIn(oscIn), .ersIn(ersIn));

	always #5 core_clk = ~core_clk;

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One edge passes first so a released strobe is never re-raised at once
	task automatic bus(input logic wr, input logic [11:0] idx,
		input logic [7:0] wd, output logic [7:0] rd);
		int i;
		@(posedge core_clk);
		address <= {idx, 2'b00};
		read <= ~wr;
		write <= wr;
		writedata <= {24'h0, wd};
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (waitrequest === 1'b0) break;
		end
		rd = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		if (i == 50) begin
			n_mismatch++;
			final_report();
		end
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		logic [7:0] x;
		bus(1'b1, idx, d, x);
	endtask

	task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00, rv);
		chk(rv, exp);
	endtask

	task automatic waitEv(output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (timerEvent !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			n_mismatch++;
			final_report();
		end
	endtask

	// Restart from zero, then time two event pulses in steady state
	task automatic run(input logic [7:0] tcon, input int exp);
		int n;
		wr(HLT_IDX_TCON, 8'h00);
		wr(HLT_IDX_COUNT, 8'h00);
		wr(HLT_IDX_TCON, tcon);
		waitEv(n);
		waitEv(n);
		chk(n, exp);
	endtask

	task automatic pin(input logic v);
		@(posedge core_clk);
		ersLevel[0] <= v;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic t_regs();
		rdc(HLT_IDX_COUNT, 8'h00);
		rdc(HLT_IDX_PERIOD, 8'hFF);
		rdc(HLT_IDX_TCON, 8'h00);
		rdc(HLT_IDX_LIMIT, 8'h00);
		rdc(HLT_IDX_CLKSRC, 8'h00);
		rdc(HLT_IDX_ERSSEL, 8'h00);
		rdc(HLT_IDX_STATUS, 8'h00);
		wr(HLT_IDX_COUNT, 8'hA5);
		rdc(HLT_IDX_COUNT, 8'hA5);
		wr(HLT_IDX_PERIOD, 8'h5A);
		rdc(HLT_IDX_PERIOD, 8'h5A);
		wr(12'h2A0, 8'h77);
		rdc(12'h2A0, 8'h00);
		$display("test regs done");
	endtask

	task automatic t_scale();
		wr(HLT_IDX_CLKSRC, {5'h00, HLT_CS_SYS});
		wr(HLT_IDX_PERIOD, 8'h01);
		for (int k = 0; k < 8; k++) begin
			run({1'b1, 3'(k), 4'h0}, 2 << k);
		end
		for (int p = 0; p < 16; p++) begin
			run({1'b1, 3'h0, 4'(p)}, 2 * (p + 1));
		end
		wr(HLT_IDX_PERIOD, 8'h05);
		run(8'h80, 6);
		wr(HLT_IDX_PERIOD, 8'hFF);
		run(8'h80, 256);
		$display("test scale done");
	endtask

	task automatic t_src();
		wr(HLT_IDX_PERIOD, 8'h01);
		for (int c = 3; c < 7; c++) begin
			wr(HLT_IDX_CLKSRC, 8'(c));
			run(8'h80, 4 * (c - 1));
		end
		wr(HLT_IDX_CLKSRC, {5'h00, HLT_CS_INSTR});
		run(8'h80, 8);
		wr(HLT_IDX_TCON, 8'h00);
		wr(HLT_IDX_CLKSRC, 8'h07);
		wr(HLT_IDX_COUNT, 8'h00);
		wr(HLT_IDX_TCON, 8'h80);
		repeat (20) @(posedge core_clk);
		rdc(HLT_IDX_COUNT, 8'h00);
		$display("test sources done");
	endtask

	task automatic t_irq();
		wr(HLT_IDX_CLKSRC, {5'h00, HLT_CS_SYS});
		run(8'h80, 2);
		wr(HLT_IDX_TCON, 8'h00);
		rdc(HLT_IDX_STATUS, 8'h03);
		chk(irq, 1'b0);
		wr(HLT_IDX_MASK, 8'h01);
		@(posedge core_clk);
		chk(irq, 1'b1);
		wr(HLT_IDX_STATUS, 8'h01);
		@(posedge core_clk);
		chk(irq, 1'b0);
		rdc(HLT_IDX_STATUS, 8'h02);
		$display("test interrupt done");
	endtask

	task automatic t_stop();
		logic [7:0] a;
		int         n;
		wr(HLT_IDX_PERIOD, 8'hFF);
		wr(HLT_IDX_TCON, 8'h80);
		repeat (30) @(posedge core_clk);
		wr(HLT_IDX_TCON, 8'h00);
		bus(1'b0, HLT_IDX_COUNT, 8'h00, a);
		repeat (10) @(posedge core_clk);
		rdc(HLT_IDX_COUNT, a);
		wr(HLT_IDX_PERIOD, 8'h03);
		wr(HLT_IDX_COUNT, 8'h00);
		wr(HLT_IDX_LIMIT, {3'h0, HLT_M_ONESHOT});
		wr(HLT_IDX_TCON, 8'h80);
		waitEv(n);
		rdc(HLT_IDX_TCON, 8'h00);
		rdc(HLT_IDX_COUNT, 8'h00);
		wr(HLT_IDX_LIMIT, 8'h00);
		$display("test stop and one-shot done");
	endtask

	// Polarity only written while off, as software must
	task automatic restart(input logic [7:0] lim);
		wr(HLT_IDX_TCON, 8'h00);
		wr(HLT_IDX_LIMIT, lim);
		wr(HLT_IDX_COUNT, 8'h00);
		wr(HLT_IDX_TCON, 8'h80);
	endtask

	task automatic t_pin();
		wr(HLT_IDX_PERIOD, 8'hFF);
		wr(HLT_IDX_CLKSRC, {5'h00, HLT_CS_PIN});
		restart(8'h00);
		pin(1'b1);
		rdc(HLT_IDX_COUNT, 8'h01);
		pin(1'b0);
		rdc(HLT_IDX_COUNT, 8'h01);
		restart(8'h40);
		pin(1'b1);
		rdc(HLT_IDX_COUNT, 8'h00);
		pin(1'b0);
		rdc(HLT_IDX_COUNT, 8'h01);
		restart(8'h20);
		repeat (3) begin
			pin(1'b1);
			pin(1'b0);
		end
		rdc(HLT_IDX_COUNT, 8'h01);
		restart(8'h00);
		sleepActive <= 1'b1;
		repeat (2) begin
			pin(1'b1);
			pin(1'b0);
		end
		sleepActive <= 1'b0;
		rdc(HLT_IDX_COUNT, 8'h02);
		restart(8'h80);
		sleepActive <= 1'b1;
		repeat (2) begin
			pin(1'b1);
			pin(1'b0);
		end
		sleepActive <= 1'b0;
		rdc(HLT_IDX_COUNT, 8'h00);
		wr(HLT_IDX_CLKSRC, {5'h00, HLT_CS_HFOSC});
		sleepActive <= 1'b1;
		@(posedge core_clk);
		chk(oscKeepAlive, 1'b1);
		wr(HLT_IDX_CLKSRC, {5'h00, HLT_CS_SYS});
		@(posedge core_clk);
		chk(oscKeepAlive, 1'b0);
		sleepActive <= 1'b0;
		$display("test pin and sleep done");
	endtask

	// Low level on the chosen source holds the counter at zero
	task automatic t_ers();
		for (int s = 0; s < 6; s++) begin
			wr(HLT_IDX_ERSSEL, 8'(s));
			ersLevel <= 5'h1F & ~(5'h01 << s);
			restart({3'h0, HLT_M_LV_LOW});
			repeat (10) @(posedge core_clk);
			rdc(HLT_IDX_COUNT, 8'h00);
			ersLevel <= 5'h1F;
			repeat (10) @(posedge core_clk);
			bus(1'b0, HLT_IDX_COUNT, 8'h00, rv);
			chk(rv != 8'h00, s < 5);
		end
		$display("test reset source done");
	endtask

	// Edge modes wait for a rising edge; monostable stops at match, stays on
	task automatic t_edge();
		ersLevel <= 5'h00;
		wr(HLT_IDX_ERSSEL, 8'h00);
		restart({3'h0, HLT_M_OS_RISE});
		repeat (10) @(posedge core_clk);
		rdc(HLT_IDX_COUNT, 8'h00);
		pin(1'b1);
		bus(1'b0, HLT_IDX_COUNT, 8'h00, rv);
		chk(rv != 8'h00, 1'b1);
		wr(HLT_IDX_PERIOD, 8'h03);
		restart({3'h0, HLT_M_MS_RISE});
		wr(HLT_IDX_STATUS, 8'h03);
		pin(1'b0);
		pin(1'b1);
		repeat (10) @(posedge core_clk);
		rdc(HLT_IDX_COUNT, 8'h00);
		rdc(HLT_IDX_TCON, 8'h80);
		rdc(HLT_IDX_STATUS, 8'h03);
		$display("test edge modes done");
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		t_regs();
		t_scale();
		t_src();
		t_irq();
		t_stop();
		t_pin();
		t_ers();
		t_edge();
		final_report();
	end
endmodule
